// >>> include/vpwe_pkg.sv
// package: constants and types of the vpw error and delay controller
// ------------------------------------------------------------------
// Overview of operation
// - no limit on message length; frames of any size pass
// - own tx error stops transmission, reports $1C, interrupt if enabled
// - crc residue over data and crc byte must be $C4, else $18
// - after crc error raise its condition and ignore bus until sof
// - invalid symbol reports $1C; while transmitting report $14 first
// - $1C stays pending behind $14 so $14 is presented first
// - eod or eof off a byte boundary is a framing error, $1C
// - active symbol received while sending eod is a framing error
// - framing error raises invalid-symbol condition, then wait for sof
// - bus stuck active blocks any transmit start until it goes passive
// - failure to drive active reports $1C, aborts, idles until new tx
// - temporary fault clears and normal operation resumes by itself
// - received break raises $1C; a state vector read clears it
// - after break wait for idle bus, then for sof
// - break can be received only, never transmitted
// - noise bits during transmit abort at once, raise invalid symbol
// - transceiver delay programmable 9 to 24 us, 1 us steps, 16 default
// - delay register takes one write after reset, readable always
// - transceiver select: 1 on-chip, 0 off-chip; program 0
// - receive polarity: 1 passes input, 0 inverts it before decoding
// - offset code 0000 is 9 us, each step adds 1 us
// - end of data request appends crc byte after the current byte
// ------------------------------------------------------------------
package vpwe_pkg;
  localparam logic [7:0] VPWE_OFF_SV = 8'h00;
  localparam logic [7:0] VPWE_OFF_DATA = 8'h04;
  localparam logic [7:0] VPWE_OFF_CTRL = 8'h08;
  localparam logic [7:0] VPWE_OFF_DLY = 8'h0C;
  localparam logic [7:0] VPWE_SV_NONE = 8'h00;
  localparam logic [7:0] VPWE_SV_LOA = 8'h14;
  localparam logic [7:0] VPWE_SV_CRC = 8'h18;
  localparam logic [7:0] VPWE_SV_INV = 8'h1C;
  localparam logic [7:0] VPWE_CRC_INIT = 8'hFF;
  localparam logic [7:0] VPWE_CRC_POLY = 8'h1D;
  localparam logic [7:0] VPWE_CRC_RESIDUE = 8'hC4;
  localparam logic [7:0] VPWE_DLY_RST = 8'h47;
  localparam int VPWE_DLY_ATE_BIT = 7;
  localparam int VPWE_DLY_POL_BIT = 6;
  localparam int VPWE_CTRL_IE_BIT = 0;
  localparam int VPWE_CTRL_EOD_BIT = 1;
  localparam int VPWE_DLY_BASE_US = 9;
  localparam int VPWE_DLY_MAX_US = 24;
  localparam int VPWE_CLK_MHZ = 250;
  localparam int VPWE_CYC_PER_US = VPWE_CLK_MHZ * 1;
  localparam logic [1:0] VPWE_RESP_OKAY = 2'h0;
  localparam logic [1:0] VPWE_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    VPWE_SYM_BIT, VPWE_SYM_SOF, VPWE_SYM_EOD, VPWE_SYM_EOF,
    VPWE_SYM_BREAK, VPWE_SYM_INVALID
  } vpwe_sym_e;

  typedef struct packed {
    logic valid;
    vpwe_sym_e kind;
    logic active;
    logic on_boundary;
  } vpwe_rx_sym_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } vpwe_byte_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic is_crc;
  } vpwe_tx_s;

  typedef enum {VPWE_RX_HUNT, VPWE_RX_FRAME, VPWE_RX_WAIT_IDLE} vpwe_rx_e;
  typedef enum {VPWE_TX_IDLE, VPWE_TX_WAIT_BUS, VPWE_TX_RUN,
                VPWE_TX_CRC} vpwe_tx_e;
endpackage

// >>> hw/vpwe_ctrl.sv
// vpw bus error handling, block transmit and delay configuration
`timescale 1ns/1ps
`default_nettype none
module vpwe_ctrl (
  input wire logic i_mclk, // core clock
  input wire logic i_rst_n, // sync reset, low
  input wire logic i_awvalid, // axi write address valid
  output logic o_awready, // axi write address ready
  input wire logic [7:0] i_awaddr, // axi write address
  input wire logic i_wvalid, // axi write data valid
  output logic o_wready, // axi write data ready
  input wire logic [31:0] i_wdata, // axi write data
  input wire logic [3:0] i_wstrb, // axi byte strobes
  output logic o_bvalid, // axi write response valid
  input wire logic i_bready, // axi write response ready
  output logic [1:0] o_bresp, // axi write response
  input wire logic i_arvalid, // axi read address valid
  output logic o_arready, // axi read address ready
  input wire logic [7:0] i_araddr, // axi read address
  output logic o_rvalid, // axi read data valid
  input wire logic i_rready, // axi read data ready
  output logic [31:0] o_rdata, // axi read data
  output logic [1:0] o_rresp, // axi read response
  input wire logic i_rxd_pin, // receive pin, async
  output logic o_rx_level, // synced, polarity fixed, 1 active
  input wire vpwe_pkg::vpwe_rx_sym_s i_rx_sym, // decoded symbol
  input wire vpwe_pkg::vpwe_byte_s i_rx_byte, // received byte
  input wire logic i_bus_idle, // decoder sees idle bus
  output vpwe_pkg::vpwe_tx_s o_tx, // byte to symbol encoder
  input wire logic i_tx_ready, // encoder takes byte
  input wire logic i_tx_eod_phase, // encoder sending eod
  input wire logic i_tx_drive_fail, // bus would not go active
  output logic o_tx_abort, // stop encoder now, pulse
  output logic o_tx_active, // transmission under way
  output logic o_irq, // interrupt request, high
  output logic [3:0] o_delay_ofs, // delay offset code
  output logic [12:0] o_delay_cyc, // delay in clock cycles
  output logic o_onchip_xcvr, // transceiver select
  output logic o_rx_enable // receiver inside a frame
);
  import vpwe_pkg::*;

  function automatic logic [7:0] vpwe_crc8(input logic [7:0] c,
                                           input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[7] ^ d[i]) begin
        r = {r[6:0], 1'b0} ^ VPWE_CRC_POLY;
      end else begin
        r = {r[6:0], 1'b0};
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // receive pin synchroniser
  // ------------------------------------------------------------
  logic rxd_s1_q;
  logic rxd_s2_q;
  logic [7:0] dly_q;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rxd_s1_q <= 1'b0;
      rxd_s2_q <= 1'b0;
    end else begin
      rxd_s1_q <= i_rxd_pin;
      rxd_s2_q <= rxd_s1_q;
    end
  end
  // some transceivers invert the line; undo it before decoding
  assign o_rx_level = dly_q[VPWE_DLY_POL_BIT] ? rxd_s2_q : !rxd_s2_q;

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  logic aw_full_q, aw_full_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic w_full_q, w_full_d;
  logic [7:0] w_data_q, w_data_d;
  logic w_lane0_q, w_lane0_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic wr_fire, rd_fire, sv_rd;
  logic wr_data, wr_ctrl, wr_dly;
  logic [7:0] wr_idx, rd_idx, sv_code, rx_last_q;
  logic ie_q, eod_q, full_q, tx_buffer_empty_flag;
  logic dly_lock_q;

  assign o_awready = !aw_full_q && !bvalid_q;
  assign o_wready = !w_full_q && !bvalid_q;
  assign o_arready = !rvalid_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign rd_fire = i_arvalid && !rvalid_q;
  assign wr_idx = {aw_addr_q[7:2], 2'b00};
  assign rd_idx = {i_araddr[7:2], 2'b00};
  assign wr_data = wr_fire && w_lane0_q && wr_idx == VPWE_OFF_DATA;
  assign wr_ctrl = wr_fire && w_lane0_q && wr_idx == VPWE_OFF_CTRL;
  assign wr_dly = wr_fire && w_lane0_q && wr_idx == VPWE_OFF_DLY;
  assign sv_rd = rd_fire && rd_idx == VPWE_OFF_SV;

  always_comb begin
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d = w_full_q;
    w_data_d = w_data_q;
    w_lane0_d = w_lane0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (i_awvalid && o_awready) begin
      aw_full_d = 1'b1;
      aw_addr_d = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      w_full_d = 1'b1;
      w_data_d = i_wdata[7:0];
      w_lane0_d = i_wstrb[0];
    end
    if (wr_fire) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      case (wr_idx)
        VPWE_OFF_SV, VPWE_OFF_DATA, VPWE_OFF_CTRL,
        VPWE_OFF_DLY: bresp_d = VPWE_RESP_OKAY;
        default: bresp_d = VPWE_RESP_SLVERR;
      endcase
    end
    if (bvalid_q && i_bready) begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && i_rready) begin
      rvalid_d = 1'b0;
    end
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rresp_d = VPWE_RESP_OKAY;
      case (rd_idx)
        VPWE_OFF_SV: rdata_d = {24'h000000, sv_code};
        VPWE_OFF_DATA: rdata_d = {24'h000000, rx_last_q};
        VPWE_OFF_CTRL: rdata_d = {28'h0000000, o_tx_active, tx_buffer_empty_flag,
                                  eod_q, ie_q};
        VPWE_OFF_DLY: rdata_d = {24'h000000, dly_q};
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = VPWE_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_full_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= VPWE_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= VPWE_RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      aw_addr_q <= aw_addr_d;
      w_full_q <= w_full_d;
      w_data_q <= w_data_d;
      w_lane0_q <= w_lane0_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ------------------------------------------------------------
  // delay configuration and control
  // ------------------------------------------------------------
  logic [7:0] dly_d;
  logic dly_lock_d, ie_d;
  always_comb begin
    dly_d = dly_q;
    dly_lock_d = dly_lock_q;
    ie_d = ie_q;
    if (wr_dly && !dly_lock_q) begin
      dly_d = w_data_q;
      dly_lock_d = 1'b1;
    end
    if (wr_ctrl) begin
      ie_d = w_data_q[VPWE_CTRL_IE_BIT];
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      dly_q <= VPWE_DLY_RST;
      dly_lock_q <= 1'b0;
      ie_q <= 1'b0;
    end else begin
      dly_q <= dly_d;
      dly_lock_q <= dly_lock_d;
      ie_q <= ie_d;
    end
  end
  assign o_delay_ofs = dly_q[3:0];
  // code 0 is the base figure, each step one more microsecond
  assign o_delay_cyc = 13'((VPWE_DLY_BASE_US + int'(dly_q[3:0]))
                           * VPWE_CYC_PER_US);
  // only the off-chip path exists; the bit is passed on as stored
  assign o_onchip_xcvr = dly_q[VPWE_DLY_ATE_BIT];

  // ------------------------------------------------------------
  // receive framing errors and crc check
  // ------------------------------------------------------------
  vpwe_rx_e rx_st_q, rx_st_d;
  vpwe_tx_e tx_st_q;
  logic [7:0] rx_crc_q, rx_crc_d, rx_last_d;
  logic set_inv, set_loa, set_crc, tx_err, tx_busy;
  assign tx_busy = tx_st_q == VPWE_TX_RUN || tx_st_q == VPWE_TX_CRC;
  assign o_rx_enable = rx_st_q == VPWE_RX_FRAME;

  always_comb begin
    rx_st_d = rx_st_q;
    rx_crc_d = rx_crc_q;
    rx_last_d = rx_last_q;
    set_inv = 1'b0;
    set_loa = 1'b0;
    set_crc = 1'b0;
    tx_err = 1'b0;
    // no byte counter at all: block frames run as long as they like
    if (i_rx_byte.valid && rx_st_q == VPWE_RX_FRAME) begin
      rx_crc_d = vpwe_crc8(rx_crc_q, i_rx_byte.data);
      rx_last_d = i_rx_byte.data;
    end
    if (tx_busy && i_tx_drive_fail) begin
      set_inv = 1'b1;
      tx_err = 1'b1;
    end
    if (rx_st_q == VPWE_RX_WAIT_IDLE && i_bus_idle) begin
      rx_st_d = VPWE_RX_HUNT;
    end
    if (i_rx_sym.valid) begin
      case (rx_st_q)
        VPWE_RX_HUNT: begin
          if (i_rx_sym.kind == VPWE_SYM_SOF) begin
            rx_st_d = VPWE_RX_FRAME;
            rx_crc_d = VPWE_CRC_INIT;
          end
        end
        VPWE_RX_FRAME: begin
          case (i_rx_sym.kind)
            VPWE_SYM_INVALID: begin
              set_inv = 1'b1;
              set_loa = tx_busy;
              tx_err = tx_busy;
              rx_st_d = VPWE_RX_HUNT;
            end
            VPWE_SYM_EOD, VPWE_SYM_EOF: begin
              if (!i_rx_sym.on_boundary) begin
                set_inv = 1'b1;
                tx_err = tx_busy;
              end else begin
                set_crc = rx_crc_q != VPWE_CRC_RESIDUE;
              end
              rx_st_d = VPWE_RX_HUNT;
            end
            default: begin
            end
          endcase
        end
        default: begin
        end
      endcase
      if (i_tx_eod_phase && i_rx_sym.active) begin
        set_inv = 1'b1;
        tx_err = 1'b1;
        rx_st_d = VPWE_RX_HUNT;
      end
      if (i_rx_sym.kind == VPWE_SYM_BREAK) begin
        set_inv = 1'b1;
        tx_err = tx_busy;
        rx_st_d = VPWE_RX_WAIT_IDLE;
      end
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rx_st_q <= VPWE_RX_HUNT;
      rx_crc_q <= VPWE_CRC_INIT;
      rx_last_q <= 8'h00;
    end else begin
      rx_st_q <= rx_st_d;
      rx_crc_q <= rx_crc_d;
      rx_last_q <= rx_last_d;
    end
  end

  // ------------------------------------------------------------
  // state vector flags
  // ------------------------------------------------------------
  logic loa_q, loa_d, inv_q, inv_d, crc_q, crc_d;
  // loss of arbitration goes out first, the invalid code waits behind
  assign sv_code = loa_q ? VPWE_SV_LOA : inv_q ? VPWE_SV_INV :
                   crc_q ? VPWE_SV_CRC : VPWE_SV_NONE;
  always_comb begin
    loa_d = loa_q;
    inv_d = inv_q;
    crc_d = crc_q;
    if (sv_rd) begin
      loa_d = loa_q ? 1'b0 : loa_q;
      inv_d = (!loa_q && inv_q) ? 1'b0 : inv_q;
      crc_d = (!loa_q && !inv_q) ? 1'b0 : crc_q;
    end
    // a new event in the clearing cycle must not be lost
    if (set_loa) begin
      loa_d = 1'b1;
    end
    if (set_inv) begin
      inv_d = 1'b1;
    end
    if (set_crc) begin
      crc_d = 1'b1;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      loa_q <= 1'b0;
      inv_q <= 1'b0;
      crc_q <= 1'b0;
    end else begin
      loa_q <= loa_d;
      inv_q <= inv_d;
      crc_q <= crc_d;
    end
  end
  assign o_irq = ie_q && (loa_q || inv_q || crc_q);

  // ------------------------------------------------------------
  // block mode transmitter
  // ------------------------------------------------------------
  vpwe_tx_e tx_st_d;
  logic [7:0] sh_q, sh_d, txc_q, txc_d;
  logic full_d, eod_d, tx_hs;
  // end of data hides the empty flag until the crc byte is out
  assign tx_buffer_empty_flag = !full_q && !eod_q;
  assign o_tx_active = tx_busy;
  // no path ever hands a break to the encoder
  always_comb begin
    o_tx.valid = (tx_st_q == VPWE_TX_RUN && full_q) ||
                 tx_st_q == VPWE_TX_CRC;
    o_tx.is_crc = tx_st_q == VPWE_TX_CRC;
    o_tx.data = (tx_st_q == VPWE_TX_CRC) ? ~txc_q : sh_q;
  end
  assign tx_hs = o_tx.valid && i_tx_ready;

  always_comb begin
    tx_st_d = tx_st_q;
    sh_d = sh_q;
    full_d = full_q;
    eod_d = eod_q;
    txc_d = txc_q;
    o_tx_abort = 1'b0;
    // a write into a full buffer is dropped; software polls first
    if (wr_data && !full_q) begin
      sh_d = w_data_q;
      full_d = 1'b1;
    end
    if (wr_ctrl && w_data_q[VPWE_CTRL_EOD_BIT]) begin
      eod_d = 1'b1;
    end
    case (tx_st_q)
      VPWE_TX_IDLE: begin
        if (full_q) begin
          tx_st_d = VPWE_TX_WAIT_BUS;
          txc_d = VPWE_CRC_INIT;
        end
      end
      VPWE_TX_WAIT_BUS: begin
        // a stuck-active line keeps us here; no fault is latched
        if (i_bus_idle && !o_rx_level) begin
          tx_st_d = VPWE_TX_RUN;
        end
      end
      VPWE_TX_RUN: begin
        if (tx_hs) begin
          txc_d = vpwe_crc8(txc_q, sh_q);
          full_d = 1'b0;
        end else if (!full_q && eod_q) begin
          tx_st_d = VPWE_TX_CRC;
        end
      end
      VPWE_TX_CRC: begin
        if (tx_hs) begin
          eod_d = 1'b0;
          tx_st_d = VPWE_TX_IDLE;
        end
      end
      default: tx_st_d = VPWE_TX_IDLE;
    endcase
    if (tx_err) begin
      tx_st_d = VPWE_TX_IDLE;
      full_d = 1'b0;
      eod_d = 1'b0;
      o_tx_abort = 1'b1;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      tx_st_q <= VPWE_TX_IDLE;
      sh_q <= 8'h00;
      full_q <= 1'b0;
      eod_q <= 1'b0;
      txc_q <= VPWE_CRC_INIT;
    end else begin
      tx_st_q <= tx_st_d;
      sh_q <= sh_d;
      full_q <= full_d;
      eod_q <= eod_d;
      txc_q <= txc_d;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  AST_CRC_FLAG: assert property (
    (i_rx_sym.valid && rx_st_q == VPWE_RX_FRAME && !tx_busy &&
     i_rx_sym.kind == VPWE_SYM_EOD && i_rx_sym.on_boundary &&
     !i_tx_eod_phase && rx_crc_q != VPWE_CRC_RESIDUE)
    |=> crc_q && rx_st_q == VPWE_RX_HUNT)
    else $error("crc error not flagged");
  AST_LOA_FIRST: assert property (
    loa_q && inv_q |-> sv_code == VPWE_SV_LOA ##1 inv_q)
    else $error("loss of arbitration not presented first");
  AST_ABORT_IDLE: assert property (
    tx_err |=> tx_st_q == VPWE_TX_IDLE && !o_tx.valid && inv_q)
    else $error("transmit error did not stop transmission");
  AST_STUCK_BUS: assert property (
    tx_st_q == VPWE_TX_WAIT_BUS && o_rx_level |=> !tx_busy)
    else $error("transmit started on active bus");
  AST_DLY_ONCE: assert property (
    dly_lock_q |=> $stable(dly_q) && dly_lock_q)
    else $error("delay register changed after first write");
  AST_DLY_RANGE: assert property (
    o_delay_cyc >= 13'(VPWE_DLY_BASE_US * VPWE_CYC_PER_US) &&
    o_delay_cyc <= 13'(VPWE_DLY_MAX_US * VPWE_CYC_PER_US))
    else $error("delay outside range");
  AST_BREAK_WAIT: assert property (
    i_rx_sym.valid && i_rx_sym.kind == VPWE_SYM_BREAK
    |=> rx_st_q == VPWE_RX_WAIT_IDLE && inv_q)
    else $error("break not followed by idle wait");
  AST_FRAMING: assert property (
    (i_rx_sym.valid && rx_st_q == VPWE_RX_FRAME &&
     (i_rx_sym.kind == VPWE_SYM_EOD || i_rx_sym.kind == VPWE_SYM_EOF) &&
     !i_rx_sym.on_boundary) |=> inv_q && rx_st_q == VPWE_RX_HUNT)
    else $error("framing error missed");
  AST_EOD_ACTIVE: assert property (
    i_rx_sym.valid && i_rx_sym.active && i_tx_eod_phase |=> inv_q)
    else $error("active symbol during eod not flagged");
  AST_CRC_APPEND: assert property (
    tx_st_q == VPWE_TX_RUN && !full_q && eod_q && !tx_err
    |=> o_tx.valid && o_tx.is_crc)
    else $error("crc byte not appended");
  AST_POLARITY: assert property (
    $past(i_rst_n, 2) && $past(i_rst_n) && $stable(dly_q) |->
    o_rx_level == (dly_q[VPWE_DLY_POL_BIT] ~^ $past(i_rxd_pin, 2)))
    else $error("receive polarity wrong");
endmodule
`default_nettype wire

// >>> dv/vpwe_far.sv
// far side model: symbol decoder, byte encoder and bus line
`timescale 1ns/1ps
`default_nettype none
module vpwe_far
  import vpwe_pkg::*;
(
  input wire logic i_mclk, // core clock
  input wire vpwe_pkg::vpwe_tx_s i_tx, // byte offer
  input wire logic i_abort, // abort pulse
  output vpwe_pkg::vpwe_rx_sym_s o_sym, // symbol event
  output vpwe_pkg::vpwe_byte_s o_byte, // received byte
  output logic o_idle, // bus idle
  output logic o_ready, // encoder ready
  output logic o_eod_phase, // sending eod
  output logic o_fail, // drive failure
  output logic o_pin // receive pin
);
  logic [7:0] txq[$];
  int aborts;
  initial begin
    o_sym = '0;
    o_byte = '0;
    o_idle = 1'b1;
    o_ready = 1'b0;
    o_eod_phase = 1'b0;
    o_fail = 1'b0;
    o_pin = 1'b0;
    aborts = 0;
  end
  // a slow encoder stalls at random
  always @(posedge i_mclk) begin
    o_ready <= ($urandom % 3) != 0;
    if (i_tx.valid && o_ready)
      txq.push_back(i_tx.data);
    if (i_abort)
      aborts++;
  end
  task automatic sym(input vpwe_sym_e k, input logic b);
    o_sym <= '{1'b1, k, 1'b1, b};
    @(posedge i_mclk);
    o_sym <= '0;
    @(posedge i_mclk);
  endtask
  // stale data flipped so no one reads a held byte
  task automatic byt(input logic [7:0] d);
    o_byte <= '{1'b1, d};
    @(posedge i_mclk);
    o_byte <= '{1'b0, ~d};
    @(posedge i_mclk);
  endtask
  task automatic lvl(input logic p, input logic f, input logic e);
    o_pin <= p;
    o_fail <= f;
    o_eod_phase <= e;
  endtask
  task automatic idl(input logic i);
    o_idle <= i;
  endtask
endmodule
`default_nettype wire

// >>> dv/vpw_bus_error_and_delay_ctrl_bench.sv
// self-checking bench of the vpw error and delay controller
`timescale 1ns/1ps
`default_nettype none
module vpw_bus_error_and_delay_ctrl_bench;
  import vpwe_pkg::*;
  logic i_mclk, i_rst_n, awv, wv, arv, one, awr, wrdy, bv, arr, rv;
  logic lvl, ab, act, irq, transceiver_select, rxe, idle, trdy, eodp, dfl, pin;
  logic [1:0] rr, rrs, br, brs;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdt, rdv;
  logic [3:0] ofs, ofo;
  logic [12:0] dcy;
  vpwe_tx_s tx;
  vpwe_rx_sym_s sym;
  vpwe_byte_s rby;
  logic [7:0] msg[$];
  int error_cnt, comparisons, cyc, n, k;

  vpwe_ctrl vpwe_ctrl_inst (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_awvalid(awv), .o_awready(awr),
    .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrdy), .i_wdata(wd),
    .i_wstrb(4'hF), .o_bvalid(bv), .i_bready(one), .o_bresp(br),
    .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv),
    .i_rready(one), .o_rdata(rdt), .o_rresp(rr), .i_rxd_pin(pin),
    .o_rx_level(lvl), .i_rx_sym(sym), .i_rx_byte(rby), .i_bus_idle(idle),
    .o_tx(tx), .i_tx_ready(trdy), .i_tx_eod_phase(eodp),
    .i_tx_drive_fail(dfl), .o_tx_abort(ab), .o_tx_active(act),
    .o_irq(irq), .o_delay_ofs(ofo), .o_delay_cyc(dcy),
    .o_onchip_xcvr(transceiver_select), .o_rx_enable(rxe));
  vpwe_far vpwe_far_inst (.i_mclk(i_mclk), .i_tx(tx), .i_abort(ab),
    .o_sym(sym), .o_byte(rby), .o_idle(idle), .o_ready(trdy),
    .o_eod_phase(eodp), .o_fail(dfl), .o_pin(pin));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // bready and rready stay high, so each wait ends on the handshake
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (awv || wv);
    do @(posedge i_mclk); while (!bv);
    brs = br;
  endtask
  task automatic axr(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    do @(posedge i_mclk); while (!arr);
    arv <= 1'b0;
    do @(posedge i_mclk); while (!rv);
    rdv = rdt;
    rrs = rr;
  endtask
  task automatic sv(input logic [7:0] e);
    axr(VPWE_OFF_SV);
    chk(rdv, {24'h0, e});
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] q[$]);
    logic [7:0] c;
    c = VPWE_CRC_INIT;
    foreach (q[i])
      for (int j = 7; j >= 0; j--)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ q[i][j]) ? VPWE_CRC_POLY : 8'h00);
    return ~c;
  endfunction

  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc > 40000) begin
      error_cnt++;
      finish_test;
    end
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    i_rst_n = 1'b0;
    awv = 1'b0;
    wv = 1'b0;
    arv = 1'b0;
    one = 1'b1;
    awa = '0;
    ara = '0;
    wd = '0;
    error_cnt = 0;
    comparisons = 0;
    cyc = 0;
    void'($urandom(32'h6932));
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    chk(dcy, (VPWE_DLY_BASE_US + 7) * VPWE_CYC_PER_US);
    chk(transceiver_select, 0);
    ofs = 4'($urandom);
    axw(VPWE_OFF_DLY, {28'h0, ofs});
    chk(brs, VPWE_RESP_OKAY);
    axw(VPWE_OFF_DLY, 32'hC5);
    axr(VPWE_OFF_DLY);
    chk(rdv, {28'h0, ofs});
    chk(dcy, (VPWE_DLY_BASE_US + ofs) * VPWE_CYC_PER_US);
    chk(ofo, ofs);
    axr(8'h10);
    chk(rrs, VPWE_RESP_SLVERR);
    axw(8'h10, 32'h0);
    chk(brs, VPWE_RESP_SLVERR);
    // inverted polarity turns the low pin into a stuck-active line
    chk(lvl, 1);
    axw(VPWE_OFF_CTRL, 32'h1);
    n = 2 + $urandom % 4;
    msg = {};
    for (k = 0; k < n; k++) begin
      do axr(VPWE_OFF_CTRL); while (!rdv[2]);
      msg.push_back(8'($urandom));
      axw(VPWE_OFF_DATA, {24'h0, msg[k]});
      if (k == 0) begin
        repeat (20) @(posedge i_mclk);
        chk(act, 0);
        vpwe_far_inst.lvl(1'b1, 1'b0, 1'b0);
      end
    end
    do axr(VPWE_OFF_CTRL); while (!rdv[2]);
    axw(VPWE_OFF_CTRL, 32'h3);
    while (vpwe_far_inst.txq.size() < n + 1) @(posedge i_mclk);
    foreach (msg[i])
      chk(vpwe_far_inst.txq[i], msg[i]);
    chk(vpwe_far_inst.txq[n], crc8(msg));
    axw(VPWE_OFF_DATA, 32'h5A);
    while (!act) @(posedge i_mclk);
    vpwe_far_inst.sym(VPWE_SYM_SOF, 1'b1);
    k = vpwe_far_inst.aborts;
    vpwe_far_inst.sym(VPWE_SYM_INVALID, 1'b0);
    chk(vpwe_far_inst.aborts, k + 1);
    chk(act, 0);
    chk(irq, 1);
    sv(VPWE_SV_LOA);
    sv(VPWE_SV_INV);
    sv(VPWE_SV_NONE);
    axw(VPWE_OFF_DATA, 32'hA5);
    while (!act) @(posedge i_mclk);
    vpwe_far_inst.lvl(1'b1, 1'b1, 1'b0);
    @(posedge i_mclk);
    vpwe_far_inst.lvl(1'b1, 1'b0, 1'b0);
    repeat (10) @(posedge i_mclk);
    chk(act, 0);
    sv(VPWE_SV_INV);
    for (int g = 0; g < 2; g++) begin
      msg = {};
      n = 1 + $urandom % 5;
      vpwe_far_inst.sym(VPWE_SYM_SOF, 1'b1);
      for (k = 0; k < n; k++) begin
        msg.push_back(8'($urandom));
        vpwe_far_inst.byt(msg[k]);
      end
      vpwe_far_inst.byt(crc8(msg) ^ 8'(g));
      vpwe_far_inst.sym(VPWE_SYM_EOD, 1'b1);
      sv(g ? VPWE_SV_CRC : VPWE_SV_NONE);
      chk(rxe, 0);
    end
    // off-boundary eod, break, active symbol under our own eod
    for (k = 0; k < 3; k++) begin
      vpwe_far_inst.sym(VPWE_SYM_SOF, 1'b1);
      vpwe_far_inst.byt(8'h11);
      vpwe_far_inst.lvl(1'b1, 1'b0, k == 2);
      vpwe_far_inst.sym(vpwe_sym_e'(k == 0 ? VPWE_SYM_EOD :
                        k == 1 ? VPWE_SYM_BREAK : VPWE_SYM_BIT), k != 0);
      vpwe_far_inst.lvl(1'b1, 1'b0, 1'b0);
      chk(rxe, 0);
      chk(irq, 1);
      sv(VPWE_SV_INV);
    end
    // bus still busy after a break: a start of frame must be ignored
    vpwe_far_inst.idl(1'b0);
    vpwe_far_inst.sym(VPWE_SYM_BREAK, 1'b1);
    vpwe_far_inst.sym(VPWE_SYM_SOF, 1'b1);
    chk(rxe, 0);
    vpwe_far_inst.idl(1'b1);
    @(posedge i_mclk);
    vpwe_far_inst.sym(VPWE_SYM_SOF, 1'b1);
    chk(rxe, 1);
    sv(VPWE_SV_INV);
    finish_test;
  end
endmodule
`default_nettype wire
